// [rtl/mbm_regs.svh]
// Constants for the burst master port: widths, limits and reset values
`ifndef MBM_REGS_SVH
`define MBM_REGS_SVH

// Bus widths
`define MBM_ADDR_W 32
`define MBM_DATA_W 32
`define MBM_BE_W 4
// Burst length field width, legal range 2 to 32
`define MBM_BCNT_W 8
// Longest burst: only the top length bit set
`define MBM_BCNT_MAX 8'h80
// Width of the owed read beat counter
`define MBM_OWED_W 16
// Write data buffer depth in words
`define MBM_BUF_DEPTH 2

// Reset values and the all-lanes byte enable
`define MBM_RST_ADDR 32'h0000_0000
`define MBM_RST_DATA 32'h0000_0000
`define MBM_RST_BCNT 8'h01
`define MBM_BE_ALL 4'hf
`define MBM_RST_BE 4'h0

`endif

// [rtl/mbm_pkg.sv]
// Types for the burst master port
package mbm_pkg;

   // Port sequencer states, one-hot
   typedef enum logic [2:0] {
      MBM_ST_IDLE  = 3'b001,
      MBM_ST_WRITE = 3'b010,
      MBM_ST_RADDR = 3'b100
   } mbm_state_t;

endpackage : mbm_pkg

// [rtl/mbm_wbuf.sv]
// Small write data buffer with valid and ready on both sides
`timescale 1ns/100ps
module mbm_wbuf #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wptr_reg;
   logic [PW-1:0] rptr_reg;
   logic [CW-1:0] cnt_reg;
   logic ready_reg;

   // Handshakes and next occupancy
   wire push = in_valid_i && ready_reg;
   wire pop = out_valid_o && out_ready_i;
   wire [CW-1:0] cnt_next = CW'(cnt_reg + CW'(push) - CW'(pop));
   wire [PW-1:0] wptr_inc = (wptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wptr_reg + 1'b1);
   wire [PW-1:0] rptr_inc = (rptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rptr_reg + 1'b1);

   assign in_ready_o = ready_reg;
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rptr_reg];

   // Pointers, count and registered ready
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b0;
      end else if (ce_i) begin
         if (push) wptr_reg <= wptr_inc;
         if (pop) rptr_reg <= rptr_inc;
         cnt_reg <= cnt_next;
         ready_reg <= (cnt_next < CW'(DEPTH)); // Full stalls the source
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && push) begin
         mem_reg[wptr_reg] <= in_data_i;
      end
   end

endmodule : mbm_wbuf

// [rtl/mbm_master.sv]
// Burst master port on a synchronous memory-mapped bus
`timescale 1ns/100ps
`include "mbm_regs.svh"

// Overview of operation
// - Burst length field is between 2 and 32 bits wide; here 8 bits.
// - Length counts sequential beats; one behaves as a plain single transfer.
// - Longest burst is two to the width minus one, top bit only set.
// - Beats may stall any number of cycles on either side.
// - Read bursts imply pipelined reads, so no shared tristate data.
// - Every started burst runs all beats; no abort, no new address during a write burst.
// - Write burst opens with address, first data, write, enables and length.
// - Address, enables and length stay constant through a write burst.
// - Write with fresh data is accepted on exactly N edges.
// - Master may drop write to pause; no data taken, burst resumes.
// - Under waitrequest the master holds write data and write unchanged.
// - All byte enables are high during every burst.
// - Read burst opens with address, read and length held through waitrequest.
// - Read data is taken on every edge with readdatavalid high.
// - After read address acceptance, a new transfer may start on that edge.
module mbm_master (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // User command port
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [`MBM_ADDR_W-1:0] cmd_addr_i,
   input wire logic [`MBM_BCNT_W-1:0] cmd_len_i,
   output logic cmd_ready_o,
   output logic cmd_err_o,
   // User write data stream
   input wire logic wr_valid_i,
   input wire logic [`MBM_DATA_W-1:0] wr_data_i,
   output logic wr_ready_o,
   output logic wr_done_o,
   // User read data stream
   output logic rd_valid_o,
   output logic [`MBM_DATA_W-1:0] rd_data_o,
   output logic busy_o,
   // Memory-mapped bus master side
   output logic [`MBM_ADDR_W-1:0] avm_address_o,
   output logic [`MBM_BCNT_W-1:0] avm_burstcount_o,
   output logic avm_write_o,
   output logic [`MBM_DATA_W-1:0] avm_writedata_o,
   output logic [`MBM_BE_W-1:0] avm_byteenable_o,
   output logic avm_read_o,
   input wire logic avm_waitrequest_i,
   input wire logic [`MBM_DATA_W-1:0] avm_readdata_i,
   input wire logic avm_readdatavalid_i
);

   // Length legality: from one up to the top-bit-only value
   function automatic logic mbm_len_ok(input logic [`MBM_BCNT_W-1:0] len);
      mbm_len_ok = (len != '0) && (len <= `MBM_BCNT_MAX);
   endfunction : mbm_len_ok

   mbm_pkg::mbm_state_t state_reg;
   mbm_pkg::mbm_state_t state_next;

   // Pending command slot
   logic pend_valid_reg;
   logic pend_write_reg;
   logic [`MBM_ADDR_W-1:0] pend_addr_reg;
   logic [`MBM_BCNT_W-1:0] pend_len_reg;
   logic cmd_ready_reg;
   logic cmd_err_reg;

   // Bus outputs
   logic [`MBM_ADDR_W-1:0] addr_reg;
   logic [`MBM_BCNT_W-1:0] bcnt_reg;
   logic write_reg;
   logic [`MBM_DATA_W-1:0] wdata_reg;
   logic [`MBM_BE_W-1:0] be_reg;
   logic read_reg;

   // Beat counters and user-facing flags
   logic [`MBM_BCNT_W-1:0] wleft_reg;
   logic [`MBM_OWED_W-1:0] owed_reg;
   logic wr_done_reg;
   logic rd_valid_reg;
   logic [`MBM_DATA_W-1:0] rd_data_reg;
   logic busy_reg;

   // Buffer read side
   logic buf_valid;
   logic [`MBM_DATA_W-1:0] buf_data;
   logic buf_ready;
   logic buf_in_ready;

   // Write data path buffer; waitrequest back-pressure reaches the user
   mbm_wbuf #(
      .WIDTH(`MBM_DATA_W),
      .DEPTH(`MBM_BUF_DEPTH)
   ) u_wbuf (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .in_valid_i(wr_valid_i),
      .in_data_i(wr_data_i),
      .in_ready_o(buf_in_ready),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_ready)
   );

   // State decode
   wire st_idle = (state_reg == mbm_pkg::MBM_ST_IDLE);
   wire st_write = (state_reg == mbm_pkg::MBM_ST_WRITE);
   wire st_raddr = (state_reg == mbm_pkg::MBM_ST_RADDR);

   // Command intake
   wire cmd_fire = cmd_valid_i && cmd_ready_reg;
   wire cmd_legal = mbm_len_ok(cmd_len_i);
   wire cmd_take = cmd_fire && cmd_legal;
   wire cmd_bad = cmd_fire && !cmd_legal;

   // Read address accepted on this edge
   wire raddr_acc = st_raddr && read_reg && !avm_waitrequest_i;
   // Owed count headroom: a read waits rather than let the counter wrap
   wire [`MBM_OWED_W-1:0] owed_lim = `MBM_OWED_W'({`MBM_OWED_W{1'b1}} - `MBM_OWED_W'(`MBM_BCNT_MAX));
   wire owed_room = (owed_reg <= owed_lim);
   // Launch only from idle or right as the read address is taken; write needs its first word
   wire launch_slot = st_idle || raddr_acc;
   wire launch = launch_slot && pend_valid_reg && (pend_write_reg ? buf_valid : owed_room);
   wire launch_wr = launch && pend_write_reg;
   wire launch_rd = launch && !pend_write_reg;

   // Write beat handling
   wire beat_acc = st_write && write_reg && !avm_waitrequest_i;
   wire out_free = !write_reg || !avm_waitrequest_i;
   wire wload = st_write && out_free && (wleft_reg != '0) && buf_valid;
   wire wlast = beat_acc && (wleft_reg == '0);
   wire [`MBM_BCNT_W-1:0] len_m1 = `MBM_BCNT_W'(pend_len_reg - 1'b1);

   // Buffer pops on the first word at launch and on each later load
   assign buf_ready = ce_i && (launch_wr || wload);

   // Owed read beats: add on launch, remove on each returned beat
   wire [`MBM_OWED_W-1:0] owed_add = launch_rd ? `MBM_OWED_W'(pend_len_reg) : '0;
   wire [`MBM_OWED_W-1:0] owed_sub = avm_readdatavalid_i ? `MBM_OWED_W'(1) : '0;
   wire [`MBM_OWED_W-1:0] owed_next = `MBM_OWED_W'(owed_reg + owed_add - owed_sub);

   // Pending slot next value
   wire pend_valid_next = cmd_take ? 1'b1 : (launch ? 1'b0 : pend_valid_reg);

   // Busy while a burst, a pending command or owed read beats remain
   wire busy_next = (state_next != mbm_pkg::MBM_ST_IDLE) || (owed_next != '0) || pend_valid_next;

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         mbm_pkg::MBM_ST_IDLE: begin
            if (launch_wr) state_next = mbm_pkg::MBM_ST_WRITE;
            else if (launch_rd) state_next = mbm_pkg::MBM_ST_RADDR;
         end
         mbm_pkg::MBM_ST_WRITE: begin
            if (wlast) state_next = mbm_pkg::MBM_ST_IDLE;
         end
         mbm_pkg::MBM_ST_RADDR: begin
            if (launch_wr) state_next = mbm_pkg::MBM_ST_WRITE;
            else if (launch_rd) state_next = mbm_pkg::MBM_ST_RADDR;
            else if (raddr_acc) state_next = mbm_pkg::MBM_ST_IDLE;
         end
         default: state_next = mbm_pkg::MBM_ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) state_reg <= mbm_pkg::MBM_ST_IDLE;
      else if (ce_i) state_reg <= state_next;
   end

   // Command slot
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         pend_valid_reg <= 1'b0;
         pend_write_reg <= 1'b0;
         pend_addr_reg <= `MBM_RST_ADDR;
         pend_len_reg <= `MBM_RST_BCNT;
      end else if (ce_i) begin
         pend_valid_reg <= pend_valid_next;
         if (cmd_take) begin
            pend_write_reg <= cmd_write_i;
            pend_addr_reg <= cmd_addr_i;
            pend_len_reg <= cmd_len_i;
         end
      end
   end

   // Intake flags
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         cmd_ready_reg <= 1'b0;
         cmd_err_reg <= 1'b0;
      end else if (ce_i) begin
         cmd_ready_reg <= !pend_valid_next;
         cmd_err_reg <= cmd_bad; // Zero or oversize length refused
      end
   end

   // Address and length: set once per burst and held
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         addr_reg <= `MBM_RST_ADDR;
         bcnt_reg <= `MBM_RST_BCNT;
      end else if (ce_i && launch) begin
         addr_reg <= pend_addr_reg;
         bcnt_reg <= pend_len_reg;
      end
   end

   // Byte enables: all lanes raised from the first launch on
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) be_reg <= `MBM_RST_BE;
      else if (ce_i && launch) be_reg <= `MBM_BE_ALL;
   end

   // Read strobe: held until the address is taken
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) read_reg <= 1'b0;
      else if (ce_i) begin
         if (launch_rd) read_reg <= 1'b1;
         else if (raddr_acc) read_reg <= 1'b0;
      end
   end

   // Write strobe: up per loaded beat, down when a beat leaves with none behind
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) write_reg <= 1'b0;
      else if (ce_i) begin
         if (launch_wr || wload) write_reg <= 1'b1;
         else if (beat_acc) write_reg <= 1'b0;
      end
   end

   // Write data and beats left, frozen while waitrequest stalls a raised write
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         wdata_reg <= `MBM_RST_DATA;
         wleft_reg <= '0;
      end else if (ce_i) begin
         if (launch_wr) begin
            wdata_reg <= buf_data;
            wleft_reg <= len_m1;
         end else if (wload) begin
            wdata_reg <= buf_data;
            wleft_reg <= `MBM_BCNT_W'(wleft_reg - 1'b1);
         end
      end
   end

   // Outstanding read beats
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) owed_reg <= '0;
      else if (ce_i) owed_reg <= owed_next;
   end

   // Read capture, one word per valid beat
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg <= `MBM_RST_DATA;
      end else if (ce_i) begin
         rd_valid_reg <= avm_readdatavalid_i;
         if (avm_readdatavalid_i) rd_data_reg <= avm_readdata_i;
      end
   end

   // Completion pulse and busy status
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         wr_done_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (ce_i) begin
         wr_done_reg <= wlast;
         busy_reg <= busy_next;
      end
   end

   // Outputs straight from flip-flops
   assign cmd_ready_o = cmd_ready_reg;
   assign cmd_err_o = cmd_err_reg;
   assign wr_ready_o = buf_in_ready;
   assign wr_done_o = wr_done_reg;
   assign rd_valid_o = rd_valid_reg;
   assign rd_data_o = rd_data_reg;
   assign busy_o = busy_reg;
   assign avm_address_o = addr_reg;
   assign avm_burstcount_o = bcnt_reg;
   assign avm_write_o = write_reg;
   assign avm_writedata_o = wdata_reg;
   assign avm_byteenable_o = be_reg;
   assign avm_read_o = read_reg;

endmodule : mbm_master

// [verif/mbm_chk_assertions.sv]
// Bus-side protocol checker for the burst master port
`timescale 1ns/100ps
`include "mbm_regs.svh"
module mbm_chk (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [31:0] avm_address_o,
   input wire logic [7:0] avm_burstcount_o,
   input wire logic avm_write_o,
   input wire logic [31:0] avm_writedata_o,
   input wire logic [3:0] avm_byteenable_o,
   input wire logic avm_read_o,
   input wire logic avm_waitrequest_i,
   input wire logic [31:0] avm_readdata_i,
   input wire logic avm_readdatavalid_i,
   input wire logic rd_valid_o,
   input wire logic [31:0] rd_data_o,
   input wire logic wr_done_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   logic [8:0] wleft_reg;
   wire wacc = avm_write_o & ~avm_waitrequest_i;
   // Write beats still owed in the open burst
   always_ff @(posedge clk_sys_i)
      if (!nrst_i) wleft_reg <= 9'h000;
      else if (wacc) wleft_reg <= (wleft_reg == 9'h000 ? {1'b0, avm_burstcount_o} : wleft_reg) - 9'h001;
   // Stall, enables, length and read capture
   property p_wr_hold; avm_write_o && avm_waitrequest_i |=> avm_write_o && $stable(avm_writedata_o); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write beat changed under stall");
   property p_be_all; avm_write_o || avm_read_o |-> avm_byteenable_o == `MBM_BE_ALL; endproperty
   a_be_all: assert property (p_be_all) else $error("partial byte enables in burst");
   property p_rd_hold; avm_read_o && avm_waitrequest_i |=> avm_read_o && $stable(avm_address_o); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read address dropped under stall");
   property p_rd_take; avm_readdatavalid_i |=> rd_valid_o && rd_data_o == $past(avm_readdata_i); endproperty
   a_rd_take: assert property (p_rd_take) else $error("read beat not taken");
   property p_len_ok; avm_write_o || avm_read_o |-> avm_burstcount_o inside {[8'h01:`MBM_BCNT_MAX]}; endproperty
   a_len_ok: assert property (p_len_ok) else $error("burst length out of range");
   // Open write burst keeps its address and length, no read meanwhile
   property p_wr_const; wleft_reg != 9'h000 |-> $stable(avm_address_o) && $stable(avm_burstcount_o); endproperty
   a_wr_const: assert property (p_wr_const) else $error("address or length moved in burst");
   property p_no_read; wleft_reg != 9'h000 |-> !avm_read_o; endproperty
   a_no_read: assert property (p_no_read) else $error("new address before burst end");
   property p_wr_end; wacc && (wleft_reg == 9'h001 || (wleft_reg == 9'h000 && avm_burstcount_o == 8'h01))
      |=> wr_done_o; endproperty
   a_wr_end: assert property (p_wr_end) else $error("burst end not flagged");
endmodule : mbm_chk

bind mbm_master mbm_chk u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avm_address_o(avm_address_o),
   .avm_burstcount_o(avm_burstcount_o), .avm_write_o(avm_write_o), .avm_writedata_o(avm_writedata_o),
   .avm_byteenable_o(avm_byteenable_o), .avm_read_o(avm_read_o), .avm_waitrequest_i(avm_waitrequest_i),
   .avm_readdata_i(avm_readdata_i), .avm_readdatavalid_i(avm_readdatavalid_i), .rd_valid_o(rd_valid_o),
   .rd_data_o(rd_data_o), .wr_done_o(wr_done_o));

// [verif/mbm_fabric.sv]
// Behavioural interconnect fabric facing the burst master port
`timescale 1ns/100ps
module mbm_fabric (
   input wire logic clk_sys_i,
   input wire logic slow_i,
   input wire logic [31:0] address_i,
   input wire logic [7:0] burstcount_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic read_i,
   output logic waitrequest_o,
   output logic [31:0] readdata_o,
   output logic readdatavalid_o
);
   logic [1:0] tick_reg = 2'h0;
   logic [31:0] wq[$];
   logic [31:0] rq[$];
   initial readdatavalid_o = 1'b0;
   initial readdata_o = 32'h0;
   // Stall every other cycle when slow
   assign waitrequest_o = slow_i & tick_reg[0];
   // Take write beats, infer read addresses, return read beats with gaps
   always @(posedge clk_sys_i) begin
      tick_reg <= tick_reg + 2'h1;
      if (write_i && !waitrequest_o) wq.push_back(writedata_i);
      readdatavalid_o <= 1'b0;
      readdata_o <= ~readdata_o; // Garbage between beats
      if (rq.size() > 0 && !(slow_i && tick_reg[1])) begin
         readdatavalid_o <= 1'b1;
         readdata_o <= rq.pop_front();
      end
      if (read_i && !waitrequest_o)
         for (int i = 0; i < burstcount_i; i++) rq.push_back(address_i + i);
   end
endmodule : mbm_fabric

// [verif/test_mm_burst_master_port.sv]
// Self-checking testbench for the burst master port
`timescale 1ns/100ps
module test_mm_burst_master_port;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic slow = 1'b0;
   logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, wr_valid_i = 1'b0;
   logic [31:0] cmd_addr_i = 32'h0, wr_data_i = 32'h0;
   logic [7:0] cmd_len_i = 8'h01;
   logic cmd_ready_o, cmd_err_o, wr_ready_o, wr_done_o, rd_valid_o, busy_o;
   logic avm_write_o, avm_read_o, avm_waitrequest_i, avm_readdatavalid_i;
   logic [31:0] rd_data_o, avm_address_o, avm_writedata_o, avm_readdata_i;
   logic [7:0] avm_burstcount_o;
   logic [3:0] avm_byteenable_o;
   int error_cnt = 0, compares = 0, dones = 0, errs = 0;
   logic [31:0] got[$];
   always #5 clk_sys_i = ~clk_sys_i;
   mbm_master uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1), .cmd_valid_i(cmd_valid_i),
      .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .cmd_ready_o(cmd_ready_o),
      .cmd_err_o(cmd_err_o), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
      .wr_done_o(wr_done_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .busy_o(busy_o),
      .avm_address_o(avm_address_o), .avm_burstcount_o(avm_burstcount_o), .avm_write_o(avm_write_o),
      .avm_writedata_o(avm_writedata_o), .avm_byteenable_o(avm_byteenable_o), .avm_read_o(avm_read_o),
      .avm_waitrequest_i(avm_waitrequest_i), .avm_readdata_i(avm_readdata_i),
      .avm_readdatavalid_i(avm_readdatavalid_i));
   mbm_fabric fab (.clk_sys_i(clk_sys_i), .slow_i(slow), .address_i(avm_address_o),
      .burstcount_i(avm_burstcount_o), .write_i(avm_write_o), .writedata_i(avm_writedata_o),
      .read_i(avm_read_o), .waitrequest_o(avm_waitrequest_i), .readdata_o(avm_readdata_i),
      .readdatavalid_o(avm_readdatavalid_i));
   // Collect user-side results
   always @(posedge clk_sys_i) begin
      if (rd_valid_o) got.push_back(rd_data_o);
      dones += wr_done_o;
      errs += cmd_err_o;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic send_cmd(input logic w, input logic [31:0] a, input logic [7:0] n, input logic keep);
      cmd_valid_i = 1'b1;
      cmd_write_i = w;
      cmd_addr_i = a;
      cmd_len_i = n;
      do @(posedge clk_sys_i); while (cmd_ready_o !== 1'b1);
      #1;
      if (!keep) cmd_valid_i = 1'b0;
   endtask : send_cmd
   task automatic feed(input logic [31:0] base, input int n, input bit gap);
      for (int i = 0; i < n; i++) begin
         wr_valid_i = 1'b1;
         wr_data_i = base + i;
         do @(posedge clk_sys_i); while (wr_ready_o !== 1'b1);
         #1;
         if (gap) begin
            wr_valid_i = 1'b0;
            @(posedge clk_sys_i) #1;
         end
      end
      wr_valid_i = 1'b0;
   endtask : feed
   task automatic t_write(input logic [31:0] a, input int n, input bit gap);
      int d;
      d = dones;
      fab.wq.delete();
      fork
         send_cmd(1'b1, a, n[7:0], 1'b0);
         feed(~a, n, gap);
      join
      wait (dones == d + 1);
      @(posedge clk_sys_i) #1;
      check(fab.wq.size(), n);
      foreach (fab.wq[i]) check(fab.wq[i], ~a + i);
   endtask : t_write
   task automatic t_read(input logic [31:0] a, input int n, input int k);
      got.delete();
      for (int j = 0; j < k; j++) send_cmd(1'b0, a + j * n, n[7:0], j < k - 1);
      wait (got.size() == n * k);
      foreach (got[i]) check(got[i], a + i);
      @(posedge clk_sys_i) #1;
      check(busy_o, 1'b0);
   endtask : t_read
   task automatic t_bad();
      int e;
      e = errs;
      send_cmd(1'b0, 32'h0, 8'h00, 1'b1);
      send_cmd(1'b1, 32'h0, 8'h81, 1'b0);
      repeat (3) @(posedge clk_sys_i);
      #1;
      check(errs, e + 2);
      check(busy_o, 1'b0);
   endtask : t_bad
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys_i);
      #1 nrst_i = 1'b1;
      t_write(32'h100, 1, 0);
      slow = 1'b1;
      t_write(32'h200, 128, 0);
      t_write(32'h300, 4, 1);
      t_read(32'h400, 4, 1);
      t_read(32'h500, 128, 1);
      t_read(32'h600, 2, 3);
      slow = 1'b0;
      t_read(32'h700, 2, 3);
      t_bad();
      summarize();
   end
   // Watchdog
   initial begin
      #300000;
      error_cnt++;
      summarize();
   end
endmodule : test_mm_burst_master_port
